// ==== rtl/gpio_port.sv ====
`timescale 1ns/1ps
module gpio_port (
	input  wire logic                                 CLK,
	input  wire logic                                 NRST,
	input  wire logic                                 HSEL,
	input  wire logic [31:0]                          HADDR,
	input  wire logic [1:0]                           HTRANS,
	input  wire logic                                 HWRITE,
	input  wire logic [2:0]                           HSIZE,
	input  wire logic [31:0]                          HWDATA,
	input  wire logic                                 HREADY,
	output logic      [31:0]                          HRDATA,
	output logic                                      HREADYOUT,
	output logic                                      HRESP,
	input  wire logic [gpio_port_pkg::NUM_LINES-1:0]  IO_IN,
	output logic      [gpio_port_pkg::NUM_LINES-1:0]  IO_OUT,
	output logic      [gpio_port_pkg::NUM_LINES-1:0]  IO_OE_N,
	output logic      [gpio_port_pkg::NUM_LINES-1:0]  IO_PULLUP_EN
);
	import gpio_port_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// reset release

	logic rst_meta_reg;
	logic rst_sync_reg;
	logic rst_n;

	// asserts at once, releases two edges later so no flop sees a runt release
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	assign rst_n = rst_sync_reg;

	////////////////////////////////////////////////////////////////////////////
	// declarations

	bus_state_t              bus_state_reg;
	bus_state_t              bus_state_next;
	logic [ADDR_W-1:0]       addr_reg;
	logic [ADDR_W-1:0]       addr_next;
	logic                    write_reg;
	logic                    write_next;
	logic                    ready_reg;
	logic                    ready_next;
	logic [31:0]             rdata_reg;
	logic [31:0]             rdata_next;
	logic                    resp_reg;
	logic                    resp_next;
	logic [CMD_W-1:0]        cmd_reg;
	logic [CMD_W-1:0]        cmd_next;
	logic [CODE_W-1:0]       result_reg;
	logic [CODE_W-1:0]       result_next;

	logic [NUM_LINES-1:0]    pin_sync;
	logic [NUM_LINES-1:0]    line_dir_in;
	logic [NUM_LINES-1:0]    line_inv;
	logic [NUM_LINES-1:0]    line_level;
	logic                    wr_phase;
	logic                    cmd_stb;
	logic                    inv_stb;
	logic                    rd_stb;
	logic [CODE_W-1:0]       cmd_sel;
	logic [CODE_W-1:0]       cmd_val;
	logic [OP_W-1:0]         cmd_op;
	logic [NUM_LINES-1:0]    line_hit;
	logic                    dir_ok;
	logic                    lvl_ok;
	logic [NUM_LINES-1:0]    wr_dir;
	logic [NUM_LINES-1:0]    wr_lvl;
	logic [31:0]             rd_word;

	////////////////////////////////////////////////////////////////////////////
	// pin synchroniser and line cells

	line_sync u_sync (
		.clk (CLK),
		.rst_n (rst_n),
		.d   (IO_IN),
		.q   (pin_sync)
	);

	genvar gi;
	generate
		for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
			io_line_cell u_cell (
				.clk        (CLK),
				.rst_n      (rst_n),
				.wr_dir     (wr_dir[gi]),
				.dir_in_bit (cmd_val == DIRECTION_IN_CODE),
				.wr_lvl     (wr_lvl[gi]),
				.lvl_bit    (cmd_val == LEVEL_HIGH_CODE),
				.wr_inv     (inv_stb),
				.inv_bit    (HWDATA[INV_LSB + gi]),
				.pin_sync   (pin_sync[gi]),
				.drive      (IO_OUT[gi]),
				.drive_en_n (IO_OE_N[gi]),
				.pullup_en  (IO_PULLUP_EN[gi]),
				.dir_in     (line_dir_in[gi]),
				.inverted   (line_inv[gi]),
				.level      (line_level[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// command decode

	// writes act in the data phase, when HWDATA is valid
	always_comb begin
		wr_phase = (bus_state_reg == BUS_ACCESS) && write_reg;
		cmd_stb  = wr_phase && (addr_reg == CMD_OFF);
		inv_stb  = wr_phase && (addr_reg == INVERT_OFF);
		cmd_sel  = HWDATA[CMD_SEL_LSB +: CODE_W];
		cmd_val  = HWDATA[CMD_VAL_LSB +: CODE_W];
		cmd_op   = HWDATA[CMD_OP_LSB +: OP_W];
		line_hit = sel_decode(cmd_sel);
		// a byte outside the two defined codes is ignored, not truncated
		dir_ok   = (cmd_val == DIRECTION_IN_CODE) || (cmd_val == DIRECTION_OUT_CODE);
		lvl_ok   = (cmd_val == LEVEL_LOW_CODE) || (cmd_val == LEVEL_HIGH_CODE);
		wr_dir   = (cmd_stb && (cmd_op == DIRECTION_WRITE_OP) && dir_ok) ? line_hit : '0;
		wr_lvl   = (cmd_stb && (cmd_op == LEVEL_WRITE_OP) && lvl_ok) ? line_hit : '0;
		rd_stb   = cmd_stb && (cmd_op == LEVEL_READ_OP);
	end

	// result of the last level read, low code on an unknown selector
	always_comb begin
		result_next = result_reg;
		cmd_next    = cmd_stb ? HWDATA[CMD_W-1:0] : cmd_reg;
		if (rd_stb) begin
			if (line_hit == '0) begin
				result_next = LEVEL_LOW_CODE;
			end else begin
				result_next = level_code(|(line_hit & line_level));
			end
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			result_reg <= LEVEL_LOW_CODE;
			cmd_reg    <= '0;
		end else begin
			result_reg <= result_next;
			cmd_reg    <= cmd_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave

	// read mux, unmapped offsets read as zero
	always_comb begin
		rd_word = '0;
		unique case (addr_reg)
			CMD_OFF:    rd_word[CMD_W-1:0] = cmd_reg;
			RESULT_OFF: rd_word[CODE_W-1:0] = result_reg;
			STATUS_OFF: begin
				rd_word[STAT_DIR_LSB +: NUM_LINES] = line_dir_in;
				rd_word[STAT_OUT_LSB +: NUM_LINES] = IO_OUT;
				rd_word[STAT_LVL_LSB +: NUM_LINES] = line_level;
			end
			INVERT_OFF: rd_word[INV_LSB +: NUM_LINES] = line_inv;
			default:    rd_word = '0;
		endcase
	end

	// one wait state on every transfer buys registered read data
	always_comb begin
		bus_state_next = bus_state_reg;
		addr_next      = addr_reg;
		write_next     = write_reg;
		ready_next     = ready_reg;
		rdata_next     = rdata_reg;
		resp_next      = HRESP_OKAY;
		unique case (bus_state_reg)
			BUS_IDLE: begin
				if (HSEL && HTRANS[HTRANS_ACTIVE_BIT] && HREADY) begin
					bus_state_next = BUS_ACCESS;
					addr_next      = HADDR[ADDR_W-1:0];
					write_next     = HWRITE;
					ready_next     = 1'b0;
				end
			end
			BUS_ACCESS: begin
				bus_state_next = BUS_IDLE;
				ready_next     = 1'b1;
				rdata_next     = write_reg ? '0 : rd_word;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			bus_state_reg <= BUS_IDLE;
			addr_reg      <= '0;
			write_reg     <= 1'b0;
			ready_reg     <= 1'b1;
			rdata_reg     <= '0;
			resp_reg      <= HRESP_OKAY;
		end else begin
			bus_state_reg <= bus_state_next;
			addr_reg      <= addr_next;
			write_reg     <= write_next;
			ready_reg     <= ready_next;
			rdata_reg     <= rdata_next;
			resp_reg      <= resp_next;
		end
	end

	assign HRDATA    = rdata_reg;
	assign HREADYOUT = ready_reg;
	assign HRESP     = resp_reg;

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!rst_n);

	chk_reset_state: assert property (
		(rst_n && !$past(rst_n)) |-> (IO_OE_N == '1) && (IO_PULLUP_EN == '1))
		else $error("lines not pulled-up inputs after reset");

	chk_pullup_dir: assert property (
		IO_PULLUP_EN == IO_OE_N)
		else $error("pull-up not matching input direction");

	chk_dir_write: assert property (
		(|wr_dir && (cmd_val == DIRECTION_OUT_CODE)) |=>
			(((~IO_OE_N) & $past(wr_dir)) == $past(wr_dir)))
		else $error("direction write did not enable drive");

	chk_other_lines: assert property (
		(|wr_dir) |=> ((IO_OE_N & ~$past(wr_dir)) == ($past(IO_OE_N) & ~$past(wr_dir))))
		else $error("direction write disturbed another line");

	chk_level_drive: assert property (
		(|wr_lvl) |=> ((IO_OUT & $past(wr_lvl)) ==
			({NUM_LINES{$past(cmd_val) == LEVEL_HIGH_CODE}} & $past(wr_lvl))))
		else $error("level write not applied to output");

	chk_bad_sel: assert property (
		(cmd_stb && (line_hit == '0)) |=> $stable(IO_OE_N) && $stable(IO_OUT))
		else $error("unknown selector changed a line");

	chk_bad_read: assert property (
		(rd_stb && (line_hit == '0)) |=> (result_reg == LEVEL_LOW_CODE))
		else $error("unknown selector read not low");

	chk_read_code: assert property (
		rd_stb |=> (result_reg == level_code(|($past(line_hit) & $past(line_level)))))
		else $error("level read returned wrong code");

	chk_sync_path: assert property (
		(IO_OE_N[0] && $past(rst_n, 2)) |->
			(line_level[0] == ($past(IO_IN[0], 2) ^ line_inv[0])))
		else $error("input level not two-flop synchronised with polarity");

	chk_out_drive: assert property (
		!IO_OE_N[1] |-> (line_level[1] == IO_OUT[1]))
		else $error("output line readback differs from drive");

	chk_bus_wait: assert property (
		(bus_state_reg == BUS_IDLE && HSEL && HTRANS[HTRANS_ACTIVE_BIT] && HREADY) |=>
			!HREADYOUT ##1 HREADYOUT)
		else $error("transfer did not take one wait state");

	chk_dir_release: assert property (
		(|wr_dir && (cmd_val == DIRECTION_IN_CODE)) |=>
			((IO_OE_N & IO_PULLUP_EN & $past(wr_dir)) == $past(wr_dir)))
		else $error("direction write did not release the line");

	chk_bad_level: assert property (
		(cmd_stb && (cmd_op == LEVEL_WRITE_OP) && !lvl_ok) |=> $stable(IO_OUT))
		else $error("undefined level byte changed an output");

	chk_inv_write: assert property (
		inv_stb |=> (line_inv == $past(HWDATA[INV_LSB +: NUM_LINES])))
		else $error("polarity write not applied");

	chk_result_hold: assert property (
		!rd_stb |=> $stable(result_reg))
		else $error("read result changed without a level read");

	chk_write_rdata: assert property (
		(bus_state_reg == BUS_ACCESS && write_reg) |=> (HRDATA == '0))
		else $error("read data not cleared after a write");

	cov_inv_write: cover property (inv_stb);
	cov_dir_out: cover property (|wr_dir && (cmd_val == DIRECTION_OUT_CODE));
	cov_read_high: cover property (rd_stb ##1 (result_reg == LEVEL_HIGH_CODE));
	cov_bad_sel: cover property (cmd_stb && (line_hit == '0));
	cov_inverted: cover property (IO_OE_N[2] && line_inv[2] && line_level[2]);

endmodule

// ==== inc/gpio_port_pkg.sv ====
// Functional notes
// - three lines, each with its own direction
// - per-line input polarity, inverted level reported complemented
// - output lines drive their stored level
// - reset makes every line pulled-up undriven input
// - selectors 0x90, 0x91, 0x92 pick one line
// - level codes are 0x00 low, 0x01 high
// - direction byte 0x01 input, 0x00 output
// - level read returns selected line state code
// - level write stores code for selected line only
package gpio_port_pkg;

	localparam int NUM_LINES = 3;
	localparam int CODE_W    = 8;
	localparam int ADDR_W    = 8;
	localparam int OP_W      = 2;

	// line selectors and byte encodings
	localparam logic [CODE_W-1:0] LINE_ONE_SELECTOR   = 8'h90;
	localparam logic [CODE_W-1:0] LINE_TWO_SELECTOR   = 8'h91;
	localparam logic [CODE_W-1:0] LINE_THREE_SELECTOR = 8'h92;
	localparam logic [CODE_W-1:0] LEVEL_LOW_CODE      = 8'h00;
	localparam logic [CODE_W-1:0] LEVEL_HIGH_CODE     = 8'h01;
	localparam logic [CODE_W-1:0] DIRECTION_IN_CODE   = 8'h01;
	localparam logic [CODE_W-1:0] DIRECTION_OUT_CODE  = 8'h00;

	// operation field of the command register
	localparam logic [OP_W-1:0] OP_NONE            = 2'h0;
	localparam logic [OP_W-1:0] LEVEL_READ_OP      = 2'h1;
	localparam logic [OP_W-1:0] LEVEL_WRITE_OP     = 2'h2;
	localparam logic [OP_W-1:0] DIRECTION_WRITE_OP = 2'h3;

	// register byte offsets
	localparam logic [ADDR_W-1:0] CMD_OFF    = 8'h00;
	localparam logic [ADDR_W-1:0] RESULT_OFF = 8'h04;
	localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h08;
	localparam logic [ADDR_W-1:0] INVERT_OFF = 8'h0c;

	// field positions
	localparam int CMD_SEL_LSB  = 0;
	localparam int CMD_VAL_LSB  = 8;
	localparam int CMD_OP_LSB   = 16;
	localparam int CMD_W        = CMD_OP_LSB + OP_W;
	localparam int STAT_DIR_LSB = 0;
	localparam int STAT_OUT_LSB = 4;
	localparam int STAT_LVL_LSB = 8;
	localparam int INV_LSB      = 0;

	// reset values
	localparam logic DIR_IN_RST = 1'b1;
	localparam logic OUT_RST    = 1'b0;
	localparam logic INV_RST    = 1'b0;

	// bus constants
	localparam int   HTRANS_ACTIVE_BIT = 1;
	localparam logic HRESP_OKAY        = 1'b0;

	typedef enum logic {
		BUS_IDLE,
		BUS_ACCESS
	} bus_state_t;

	// one-hot line hit for a selector code, zero for an unknown code
	function automatic logic [NUM_LINES-1:0] sel_decode(input logic [CODE_W-1:0] sel);
		logic [NUM_LINES-1:0] hit;
		hit = '0;
		unique case (sel)
			LINE_ONE_SELECTOR:   hit = 3'h1;
			LINE_TWO_SELECTOR:   hit = 3'h2;
			LINE_THREE_SELECTOR: hit = 3'h4;
			default:             hit = '0;
		endcase
		return hit;
	endfunction

	// level bit to byte code
	function automatic logic [CODE_W-1:0] level_code(input logic lvl);
		return lvl ? LEVEL_HIGH_CODE : LEVEL_LOW_CODE;
	endfunction

endpackage

// ==== rtl/line_sync.sv ====
`timescale 1ns/1ps
module line_sync (
	input  wire logic                                 clk,
	input  wire logic                                 rst_n,
	input  wire logic [gpio_port_pkg::NUM_LINES-1:0]  d,
	output logic      [gpio_port_pkg::NUM_LINES-1:0]  q
);
	import gpio_port_pkg::*;

	logic [NUM_LINES-1:0] meta_reg;
	logic [NUM_LINES-1:0] meta_next;
	logic [NUM_LINES-1:0] sync_reg;
	logic [NUM_LINES-1:0] sync_next;

	// first stage feeds only the second stage, pins are asynchronous to CLK
	always_comb begin
		meta_next = d;
		sync_next = meta_reg;
	end

	// pull-ups idle the lines high, so both stages reset high
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '1;
			sync_reg <= '1;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign q = sync_reg;

endmodule

// ==== rtl/io_line_cell.sv ====
`timescale 1ns/1ps
module io_line_cell (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic wr_dir,
	input  wire logic dir_in_bit,
	input  wire logic wr_lvl,
	input  wire logic lvl_bit,
	input  wire logic wr_inv,
	input  wire logic inv_bit,
	input  wire logic pin_sync,
	output logic      drive,
	output logic      drive_en_n,
	output logic      pullup_en,
	output logic      dir_in,
	output logic      inverted,
	output logic      level
);
	import gpio_port_pkg::*;

	logic dir_in_reg;
	logic dir_in_next;
	logic out_reg;
	logic out_next;
	logic inv_reg;
	logic inv_next;
	logic oe_n_reg;
	logic oe_n_next;
	logic pull_reg;
	logic pull_next;

	// each line keeps its own settings, so one line never disturbs another
	always_comb begin
		dir_in_next = wr_dir ? dir_in_bit : dir_in_reg;
		out_next    = wr_lvl ? lvl_bit : out_reg;
		inv_next    = wr_inv ? inv_bit : inv_reg;
		oe_n_next   = dir_in_next;
		pull_next   = dir_in_next;
	end

	// enable and pull-up are their own flops so the pins come from registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dir_in_reg <= DIR_IN_RST;
			out_reg    <= OUT_RST;
			inv_reg    <= INV_RST;
			oe_n_reg   <= DIR_IN_RST;
			pull_reg   <= DIR_IN_RST;
		end else begin
			dir_in_reg <= dir_in_next;
			out_reg    <= out_next;
			inv_reg    <= inv_next;
			oe_n_reg   <= oe_n_next;
			pull_reg   <= pull_next;
		end
	end

	assign drive      = out_reg;
	assign drive_en_n = oe_n_reg;
	assign pullup_en  = pull_reg;
	assign dir_in     = dir_in_reg;
	assign inverted   = inv_reg;
	// inputs report the synchronised pin through the polarity setting
	assign level      = dir_in_reg ? (pin_sync ^ inv_reg) : out_reg;

endmodule

// ==== test/ext_equipment.sv ====
`timescale 1ns/1ps
// far-side equipment on the three lines: drives a line only when told to
module ext_equipment (
	input  wire logic                                 clk,
	input  wire logic [gpio_port_pkg::NUM_LINES-1:0]  io_out,
	input  wire logic [gpio_port_pkg::NUM_LINES-1:0]  io_oe_n,
	input  wire logic [gpio_port_pkg::NUM_LINES-1:0]  io_pullup_en,
	input  wire logic [gpio_port_pkg::NUM_LINES-1:0]  ext_en,
	input  wire logic [gpio_port_pkg::NUM_LINES-1:0]  ext_val,
	output logic      [gpio_port_pkg::NUM_LINES-1:0]  pin
);
	import gpio_port_pkg::*;

	logic [NUM_LINES-1:0] last_reg;

	////////////////////////////////////////////////////////////////
	// wire level: device drive, then equipment, then pull-up
	// a floating line flips so an unknown never reads as a level
	always_comb begin
		for (int i = 0; i < NUM_LINES; i++) begin
			if (!io_oe_n[i])
				pin[i] = io_out[i];
			else if (ext_en[i])
				pin[i] = ext_val[i];
			else if (io_pullup_en[i])
				pin[i] = 1'b1;
			else
				pin[i] = ~last_reg[i];
		end
	end

	// remember the last level for the floating case
	always_ff @(posedge clk) begin
		last_reg <= pin;
	end
endmodule

// ==== test/three_line_gpio_port_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin mismatches++; \
	$display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module three_line_gpio_port_tb_top;
	import gpio_port_pkg::*;

	logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0] htrans = 0;
	logic hreadyout, hresp;
	logic [2:0] io_in, io_out, io_oe_n, io_pu, ext_en = 0, ext_val = 0;
	logic [2:0] dir_m, out_m, inv_m;
	logic [7:0] res_m;
	int mismatches = 0, cmp_count = 0, cyc = 0;

	gpio_port dut (.CLK(clk), .NRST(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
		.HREADYOUT(hreadyout), .HRESP(hresp), .IO_IN(io_in), .IO_OUT(io_out),
		.IO_OE_N(io_oe_n), .IO_PULLUP_EN(io_pu));
	ext_equipment far (.clk(clk), .io_out(io_out), .io_oe_n(io_oe_n), .io_pullup_en(io_pu),
		.ext_en(ext_en), .ext_val(ext_val), .pin(io_in));

	////////////////////////////////////////////////////////////////
	initial begin
		forever #2 clk = ~clk;
	end

	// hang guard: the whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// one single AHB-Lite word transfer, waiting on hready each phase
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
		`CHK("hresp", 1'b0, hresp)
	endtask

	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		dir_m = 3'h7;
		out_m = 3'h0;
		inv_m = 3'h0;
		res_m = 8'h00;
	endtask

	// expected level of a line worked out from the bench's own state
	function automatic logic lvl(int i);
		return dir_m[i] ? ((ext_en[i] ? ext_val[i] : 1'b1) ^ inv_m[i]) : out_m[i];
	endfunction

	// issue a command and follow it in the bench's state
	task automatic do_op(input logic [7:0] sel, input logic [7:0] val, input logic [1:0] op);
		int idx;
		idx = (sel >= 8'h90 && sel <= 8'h92) ? int'(sel - 8'h90) : -1;
		ahb(1'b1, CMD_OFF, {14'h0, op, val, sel});
		if (op == LEVEL_READ_OP)
			res_m = (idx >= 0 && lvl(idx)) ? 8'h01 : 8'h00;
		else if (idx >= 0 && val <= 8'h01 && op == LEVEL_WRITE_OP)
			out_m[idx] = val[0];
		else if (idx >= 0 && val <= 8'h01 && op == DIRECTION_WRITE_OP)
			dir_m[idx] = val[0];
	endtask

	task automatic check_state();
		logic [2:0] lv;
		for (int i = 0; i < 3; i++) lv[i] = lvl(i);
		ahb(1'b0, STATUS_OFF, 32'h0);
		`CHK("status", {21'h0, lv, 1'b0, out_m, 1'b0, dir_m}, rd)
		`CHK("oe_n", dir_m, io_oe_n)
		`CHK("pullup", dir_m, io_pu)
		`CHK("out", out_m, io_out)
		`CHK("pin", lv ^ (inv_m & dir_m), io_in)
		ahb(1'b0, RESULT_OFF, 32'h0);
		`CHK("result", {24'h0, res_m}, rd)
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		do_reset();
		check_state();
		ahb(1'b0, INVERT_OFF, 32'h0);
		`CHK("invert", 32'h0, rd)
		// every selector, the unknown 0x93 last, through every operation
		for (int s = 0; s < 4; s++) begin
			do_op(8'h90 + s[7:0], 8'h00, DIRECTION_WRITE_OP);
			check_state();
			do_op(8'h90 + s[7:0], 8'h01, LEVEL_WRITE_OP);
			check_state();
			do_op(8'h90 + s[7:0], 8'h02, LEVEL_WRITE_OP);
			do_op(8'h90 + s[7:0], 8'h02, DIRECTION_WRITE_OP);
			do_op(8'h90 + s[7:0], 8'h00, LEVEL_READ_OP);
			check_state();
		end
		// line two back to input, held low from outside
		do_op(LINE_TWO_SELECTOR, DIRECTION_IN_CODE, DIRECTION_WRITE_OP);
		ext_en <= 3'h2;
		repeat (4) @(posedge clk);
		do_op(LINE_TWO_SELECTOR, 8'h00, LEVEL_READ_OP);
		check_state();
		// invert set on an output line too: it must not touch output readback
		ahb(1'b1, INVERT_OFF, 32'h3);
		inv_m = 3'h3;
		do_op(LINE_TWO_SELECTOR, 8'h00, LEVEL_READ_OP);
		check_state();
		do_op(LINE_ONE_SELECTOR, 8'h00, LEVEL_READ_OP);
		check_state();
		ext_val <= 3'h2;
		repeat (4) @(posedge clk);
		do_op(LINE_TWO_SELECTOR, 8'h00, LEVEL_READ_OP);
		check_state();
		// a command with no operation is kept for readback but changes nothing
		do_op(LINE_ONE_SELECTOR, LEVEL_LOW_CODE, OP_NONE);
		ahb(1'b0, CMD_OFF, 32'h0);
		`CHK("cmd", {14'h0, OP_NONE, LEVEL_LOW_CODE, LINE_ONE_SELECTOR}, rd)
		// read-only and unmapped places
		ahb(1'b1, STATUS_OFF, 32'hffffffff);
		check_state();
		ahb(1'b0, 8'h10, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		// reset again in mid-run
		ext_en <= 3'h0;
		do_reset();
		check_state();
		// line three inverted and held low from outside: it reads high
		ahb(1'b1, INVERT_OFF, 32'h4);
		inv_m = 3'h4;
		ahb(1'b0, INVERT_OFF, 32'h0);
		`CHK("invert", 32'h4, rd)
		ext_en <= 3'h4;
		repeat (4) @(posedge clk);
		do_op(LINE_THREE_SELECTOR, 8'h00, LEVEL_READ_OP);
		check_state();
		end_sim();
	end
endmodule
